// *** common/debug_regs_defines.svh ***
`ifndef DEBUG_REGS_DEFINES_SVH
`define DEBUG_REGS_DEFINES_SVH

// ------------------------------------------------------------
// Host command bytes
// ------------------------------------------------------------
`define CMD_READ_STATUS 8'h02
`define CMD_WRITE_CTL 8'h04
`define CMD_READ_CTL 8'h05

// ------------------------------------------------------------
// Control register layout
// ------------------------------------------------------------
`define CTL_HALT_BIT 7
`define CTL_BRK_EN_BIT 6
`define CTL_ACK_EN_BIT 5
`define CTL_RSV_HI 4
`define CTL_RSV_LO 1
`define CTL_RST_BIT 0
`define CTL_RESET_VAL 8'h00

// ------------------------------------------------------------
// Status register layout
// ------------------------------------------------------------
`define STAT_DEBUG_BIT 7
`define STAT_LP_HALT_BIT 6
`define STAT_RP_INACTIVE_BIT 5
`define STAT_RSV_ZERO 5'h00
`define STAT_RESET_VAL 8'h00

// ------------------------------------------------------------
// Opcodes and link bytes
// ------------------------------------------------------------
`define BRK_OPCODE 8'h00
`define ACK_BYTE 8'hFF

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define RESET_HOLD_NS 1000
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CNT_W 8

`endif

// *** common/debug_regs_pkg.sv ***
package debug_regs_pkg;

	// ------------------------------------------------------------
	// Link and core carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} host_byte_t;

	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
	} decode_t;

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_WDATA = 2'b01
	} cmd_state_t;

	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_HOLD = 1'b1
	} seq_state_t;

endpackage : debug_regs_pkg

// *** rtl/onchip_debugger_regs.sv ***
`timescale 1ns/100ps
`include "debug_regs_defines.svh"


module onchip_debugger_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Host byte link
	input debug_regs_pkg::host_byte_t host_rx,
	output logic host_rx_ready,
	output debug_regs_pkg::host_byte_t host_tx,
	input wire logic host_tx_ready,
	// Core side
	input debug_regs_pkg::decode_t cpu_decode,
	input wire logic cpu_low_power_halt,
	input wire logic read_protect_on,
	output logic fetch_stop,
	output logic break_taken,
	output logic device_reset
);
	import debug_regs_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	cmd_state_t state_q, state_d;
	logic [7:0] debugger_control_reg_q, debugger_control_reg_d;
	logic [7:0] debugger_status_reg;
	logic [7:0] reply_q, reply_d;
	logic reply_pend_q, reply_pend_d;
	logic ack_pend_q, ack_pend_d;
	host_byte_t tx_q, tx_d;
	logic break_taken_q, break_taken_d;
	logic rx_fire;
	logic wr_fire;
	logic brk_hit;
	logic seq_start;
	logic seq_done;
	logic seq_reset;
	logic tx_free;
	logic halt_for_debug_bit;
	logic breakpoint_enable_bit;
	logic break_ack_enable_bit;

	assign halt_for_debug_bit = debugger_control_reg_q[`CTL_HALT_BIT];
	assign breakpoint_enable_bit = debugger_control_reg_q[`CTL_BRK_EN_BIT];
	assign break_ack_enable_bit = debugger_control_reg_q[`CTL_ACK_EN_BIT];

	// ------------------------------------------------------------
	// Status view
	// ------------------------------------------------------------
	// Built live from the halt bit and the core inputs, never stored, so a read shows
	// the state at the edge the read command is taken
	always_comb begin
		debugger_status_reg = `STAT_RESET_VAL;
		debugger_status_reg[`STAT_DEBUG_BIT] = halt_for_debug_bit;
		debugger_status_reg[`STAT_LP_HALT_BIT] = cpu_low_power_halt;
		debugger_status_reg[`STAT_RP_INACTIVE_BIT] = ~read_protect_on;
		debugger_status_reg[4:0] = `STAT_RSV_ZERO;
	end

	// ------------------------------------------------------------
	// Breakpoint detection
	// ------------------------------------------------------------
	// Core is held while its reset runs, so decodes are disregarded then
	// Opcodes other than the breakpoint opcode never reach the halt bit,
	// and with breakpoints off the core simply runs the opcode as a no-op
	always_comb begin
		brk_hit = cpu_decode.valid && !seq_reset
			&& (cpu_decode.opcode == `BRK_OPCODE)
			&& breakpoint_enable_bit;
	end

	// ------------------------------------------------------------
	// Command decoder
	// ------------------------------------------------------------
	// Stall intake while a reply is unsent; keeps replies in command order
	// Trade-off: one reply slot only, so back to back reads run at the
	// pace of the host's receive side
	assign host_rx_ready = !reply_pend_q;
	assign rx_fire = host_rx.valid && host_rx_ready;
	assign wr_fire = rx_fire && (state_q == CMD_WDATA);

	always_comb begin
		state_d = state_q;
		reply_d = reply_q;
		reply_pend_d = reply_pend_q;
		if (tx_free && reply_pend_q) begin
			reply_pend_d = 1'b0;
		end
		case (state_q)
			CMD_IDLE: begin
				if (rx_fire) begin
					case (host_rx.data)
						`CMD_WRITE_CTL: begin
							state_d = CMD_WDATA;
						end
						`CMD_READ_CTL: begin
							reply_d = debugger_control_reg_q;
							reply_pend_d = 1'b1;
						end
						`CMD_READ_STATUS: begin
							reply_d = debugger_status_reg;
							reply_pend_d = 1'b1;
						end
						default: begin
							state_d = CMD_IDLE;
						end
					endcase
				end
			end
			CMD_WDATA: begin
				if (rx_fire) begin
					state_d = CMD_IDLE;
				end
			end
			default: begin
				state_d = CMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= CMD_IDLE;
			reply_q <= 8'h00;
			reply_pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			reply_q <= reply_d;
			reply_pend_q <= reply_pend_d;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Only the power-on reset clears all of this; the requested device reset
	// only clears bit 0 as it ends, so a halt written with the request survives
	always_comb begin
		debugger_control_reg_d = debugger_control_reg_q;
		if (seq_done) begin
			debugger_control_reg_d[`CTL_RST_BIT] = 1'b0;
		end
		if (wr_fire) begin
			// Protected: a 1 may be written, a 0 cannot clear it
			debugger_control_reg_d[`CTL_HALT_BIT] = host_rx.data[`CTL_HALT_BIT]
				|| (halt_for_debug_bit && read_protect_on);
			debugger_control_reg_d[`CTL_BRK_EN_BIT] =
				host_rx.data[`CTL_BRK_EN_BIT];
			debugger_control_reg_d[`CTL_ACK_EN_BIT] =
				host_rx.data[`CTL_ACK_EN_BIT];
			if (host_rx.data[`CTL_RST_BIT]) begin
				debugger_control_reg_d[`CTL_RST_BIT] = 1'b1;
			end
		end
		// Reserved bits never store what the host sends
		debugger_control_reg_d[`CTL_RSV_HI:`CTL_RSV_LO] = 4'h0;
		if (brk_hit) begin
			debugger_control_reg_d[`CTL_HALT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			debugger_control_reg_q <= `CTL_RESET_VAL;
		end else begin
			debugger_control_reg_q <= debugger_control_reg_d;
		end
	end

	// ------------------------------------------------------------
	// Device reset request
	// ------------------------------------------------------------
	// A 0 in bit 0 starts nothing; a repeated 1 restarts the hold
	assign seq_start = wr_fire && host_rx.data[`CTL_RST_BIT];

	reset_sequencer u_reset_sequencer (
		.mclk(mclk),
		.rst(rst),
		.start(seq_start),
		.sys_reset(seq_reset),
		.done(seq_done)
	);

	assign device_reset = seq_reset;

	// ------------------------------------------------------------
	// Acknowledge and reply transmit
	// ------------------------------------------------------------
	// Register is free when empty or being emptied at this edge
	assign tx_free = !tx_q.valid || host_tx_ready;

	always_comb begin
		tx_d = tx_q;
		ack_pend_d = ack_pend_q;
		if (tx_q.valid && host_tx_ready) begin
			tx_d.valid = 1'b0;
		end
		// Replies go first; a pending acknowledge waits one slot
		if (tx_free && reply_pend_q) begin
			tx_d.valid = 1'b1;
			tx_d.data = reply_q;
		end else if (tx_free && ack_pend_q) begin
			tx_d.valid = 1'b1;
			tx_d.data = `ACK_BYTE;
			ack_pend_d = 1'b0;
		end
		// A new breakpoint wins over the clear of the old one
		if (brk_hit && break_ack_enable_bit) begin
			ack_pend_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_q <= '0;
			ack_pend_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			ack_pend_q <= ack_pend_d;
		end
	end

	assign host_tx = tx_q;

	// ------------------------------------------------------------
	// Core controls
	// ------------------------------------------------------------
	// One-cycle pulse, lined up with the halt bit it sets
	assign break_taken_d = brk_hit;

	always_ff @(posedge mclk) begin
		if (rst) begin
			break_taken_q <= 1'b0;
		end else begin
			break_taken_q <= break_taken_d;
		end
	end

	assign break_taken = break_taken_q;
	// Follows the stored bit directly; the requested device reset does
	// not touch it, so a halt written with the request outlasts it
	assign fetch_stop = halt_for_debug_bit;

endmodule : onchip_debugger_regs

// *** rtl/reset_sequencer.sv ***
`timescale 1ns/100ps
`include "debug_regs_defines.svh"

module reset_sequencer (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Request
	input wire logic start,
	// Sequence state
	output logic sys_reset,
	output logic done
);
	import debug_regs_pkg::*;

	localparam logic [`RESET_CNT_W-1:0] HOLD_LAST =
		`RESET_CNT_W'(`RESET_HOLD_CYCLES - 1);

	seq_state_t state_q, state_d;
	logic [`RESET_CNT_W-1:0] cnt_q, cnt_d;
	logic done_q, done_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		case (state_q)
			SEQ_IDLE: begin
				if (start) begin
					state_d = SEQ_HOLD;
					cnt_d = '0;
				end
			end
			SEQ_HOLD: begin
				// A fresh request restarts the hold rather than queueing
				if (start) begin
					cnt_d = '0;
				end else if (cnt_q == HOLD_LAST) begin
					state_d = SEQ_IDLE;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= SEQ_IDLE;
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign sys_reset = (state_q == SEQ_HOLD);
	assign done = done_q;

endmodule : reset_sequencer

// *** verif/debug_regs_properties.sv ***
`timescale 1ns/100ps
`include "debug_regs_defines.svh"

module debug_regs_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Host link
	input debug_regs_pkg::host_byte_t host_rx,
	input wire logic host_rx_ready,
	input debug_regs_pkg::host_byte_t host_tx,
	input wire logic host_tx_ready,
	// Core side
	input debug_regs_pkg::decode_t cpu_decode,
	input wire logic cpu_low_power_halt,
	input wire logic read_protect_on,
	input wire logic fetch_stop,
	input wire logic break_taken,
	input wire logic device_reset
);
	import debug_regs_pkg::*;

	// ----------------
	// Helpers
	// ----------------
	// Data byte of a write must not be mistaken for a command
	logic take, data_q, data_d;
	logic [7:0] len_q, len_d;
	assign take = host_rx.valid && host_rx_ready;
	always_comb begin
		data_d = data_q;
		len_d = device_reset ? len_q + 8'h01 : 8'h00;
		if (take) begin
			data_d = !data_q && host_rx.data == `CMD_WRITE_CTL;
		end
		if (rst) begin
			data_d = 1'h0;
			len_d = 8'h00;
		end
	end
	always_ff @(posedge mclk) begin
		data_q <= data_d;
		len_q <= len_d;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	AST_HOLD_LEN: assert property ($fell(device_reset) |-> len_q == 8'(`RESET_HOLD_CYCLES))
		else $error("device reset length wrong");
	AST_BRK_CAUSE: assert property ($rose(break_taken) |-> $past(cpu_decode.valid)
		&& $past(cpu_decode.opcode) == `BRK_OPCODE) else $error("break without opcode");
	AST_BRK_HALT: assert property (break_taken |-> fetch_stop)
		else $error("break without halt");
	AST_NOP: assert property (cpu_decode.valid && cpu_decode.opcode != `BRK_OPCODE |=> !break_taken)
		else $error("break on other opcode");
	AST_PROTECT: assert property (read_protect_on && fetch_stop |=> fetch_stop)
		else $error("halt cleared under protect");
	AST_TX_HOLD: assert property (host_tx.valid && !host_tx_ready |=> host_tx.valid && $stable(host_tx.data))
		else $error("tx byte not held");
	AST_REFUSE: assert property (take && !data_q && host_rx.data == `CMD_READ_CTL |=> !host_rx_ready)
		else $error("byte taken with reply unsent");
	AST_STAT_REPLY: assert property (take && !data_q && host_rx.data == `CMD_READ_STATUS |-> ##[1:60] host_tx.valid)
		else $error("status reply missing");
	AST_WR_RST: assert property (take && data_q && host_rx.data[0] |-> ##[1:2] device_reset)
		else $error("reset request ignored");
	AST_WR_HALT: assert property (take && data_q && host_rx.data[7] |-> ##[1:2] fetch_stop)
		else $error("halt write ignored");
	AST_WR_RUN: assert property (take && data_q && !host_rx.data[7] && !read_protect_on |-> ##[1:2] !fetch_stop)
		else $error("run write ignored");

	cover property (break_taken);
	cover property ($fell(device_reset));
	cover property (host_tx.valid && host_tx_ready);
endmodule : debug_regs_properties

bind onchip_debugger_regs debug_regs_properties u_props (.mclk, .rst, .host_rx, .host_rx_ready,
	.host_tx, .host_tx_ready, .cpu_decode, .cpu_low_power_halt, .read_protect_on, .fetch_stop,
	.break_taken, .device_reset);

// *** verif/host_model.sv ***
`timescale 1ns/100ps

module host_model (
	// Clock
	input wire logic mclk,
	// Link
	output debug_regs_pkg::host_byte_t host_rx,
	input wire logic host_rx_ready,
	input debug_regs_pkg::host_byte_t host_tx,
	output logic host_tx_ready
);
	import debug_regs_pkg::*;

	initial begin
		host_rx = '0;
		host_tx_ready = 1'h0;
	end

	// Byte held until taken; released line shows inverted data
	task send(input logic [7:0] b);
		@(negedge mclk);
		host_rx <= {1'h1, b};
		#1;
		while (host_rx_ready !== 1'h1) begin
			@(negedge mclk);
			#1;
		end
		@(negedge mclk);
		host_rx <= {1'h0, ~b};
	endtask : send

	// Listens only inside the call so no byte is lost unseen
	task recv(input int stall, output logic [7:0] b);
		b = 'x;
		repeat (stall + 1) @(negedge mclk);
		host_tx_ready <= 1'h1;
		repeat (100) begin
			#1;
			if (host_tx.valid === 1'h1) begin
				b = host_tx.data;
				break;
			end
			@(negedge mclk);
		end
		@(negedge mclk);
		host_tx_ready <= 1'h0;
	endtask : recv
endmodule : host_model

// *** verif/tb.sv ***
`timescale 1ns/100ps
`include "debug_regs_defines.svh"

module tb;
	import debug_regs_pkg::*;

	logic mclk, rst, host_rx_ready, host_tx_ready, cpu_low_power_halt, read_protect_on;
	logic fetch_stop, break_taken, device_reset;
	host_byte_t host_rx, host_tx;
	decode_t cpu_decode;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] seed;
	logic [7:0] ctl_m, b;

	onchip_debugger_regs DUT (.mclk, .rst, .host_rx, .host_rx_ready, .host_tx, .host_tx_ready,
		.cpu_decode, .cpu_low_power_halt, .read_protect_on, .fetch_stop, .break_taken,
		.device_reset);
	host_model host (.mclk, .host_rx, .host_rx_ready, .host_tx, .host_tx_ready);

	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end

	// ----------------
	// Expectations
	// ----------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Protect keeps a set halt bit; reserved and reset bits read zero
	function logic [7:0] next_ctl(input logic [7:0] v);
		return {v[7] | (read_protect_on & ctl_m[7]), v[6:5], 5'h00};
	endfunction : next_ctl

	function logic [7:0] stat_exp();
		return {ctl_m[7], cpu_low_power_halt, ~read_protect_on, 5'h00};
	endfunction : stat_exp

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] v);
		host.send(`CMD_WRITE_CTL);
		host.send(v);
		ctl_m = next_ctl(v);
		@(negedge mclk);
	endtask : wr

	task rd(input logic [7:0] cmd, input logic [7:0] exp);
		host.send(cmd);
		host.recv(int'(seed[2:0]), b);
		chk(b, exp);
	endtask : rd

	task breakpoint_opcode(input logic [7:0] op, input logic hit);
		@(negedge mclk);
		cpu_decode <= {1'h1, op};
		@(negedge mclk);
		cpu_decode <= {1'h0, ~op};
		chk(break_taken, hit);
		ctl_m[7] = ctl_m[7] | hit;
	endtask : breakpoint_opcode

	task close_out();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	initial begin
		rst = 1'h1;
		cpu_low_power_halt = 1'h0;
		read_protect_on = 1'h0;
		cpu_decode = '0;
		seed = 32'h5FEA;
		ctl_m = 8'h00;
		repeat (10) @(negedge mclk);
		rst = 1'h0;
		rd(`CMD_READ_CTL, 8'h00);
		rd(`CMD_READ_STATUS, stat_exp());
		host.send(8'h07);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			cpu_low_power_halt = seed[3];
			wr(seed[15:8] & 8'hE0);
			chk(fetch_stop, ctl_m[7]);
			rd(`CMD_READ_CTL, ctl_m);
			rd(`CMD_READ_STATUS, stat_exp());
		end
		wr(8'h3E);
		rd(`CMD_READ_CTL, ctl_m);
		wr(8'h60);
		breakpoint_opcode(8'h12, 1'h0);
		breakpoint_opcode(`BRK_OPCODE, 1'h1);
		host.recv(0, b);
		chk(b, `ACK_BYTE);
		rd(`CMD_READ_CTL, ctl_m);
		wr(8'h40);
		chk(fetch_stop, 1'h0);
		wr(8'h00);
		breakpoint_opcode(`BRK_OPCODE, 1'h0);
		wr(8'h40);
		breakpoint_opcode(`BRK_OPCODE, 1'h1);
		repeat (3) @(negedge mclk);
		chk(host_tx.valid, 1'h0);
		read_protect_on = 1'h1;
		wr(8'h00);
		chk(fetch_stop, 1'h1);
		rd(`CMD_READ_STATUS, stat_exp());
		wr(8'h81);
		chk(device_reset, 1'h1);
		repeat (60) @(negedge mclk);
		chk(device_reset, 1'h0);
		rd(`CMD_READ_CTL, ctl_m);
		chk(fetch_stop, 1'h1);
		read_protect_on = 1'h0;
		wr(8'h41);
		repeat (60) @(negedge mclk);
		rd(`CMD_READ_CTL, ctl_m);
		chk(fetch_stop, 1'h0);
		close_out();
	end
endmodule : tb
